/* rtl/hsid_pkg.sv */
`default_nettype none
package hsid_pkg;
  // Descriptor word 0.
  localparam int EPNUM_LSB_POS  = 31;
  localparam int MULT_LSB       = 29;
  localparam int MULT_W         = 2;
  localparam int MAXPKT_LSB     = 18;
  localparam int MAXPKT_W       = 11;
  localparam int XFER_LSB       = 3;
  localparam int VALID_POS      = 0;
  // Descriptor word 1.
  localparam int EPNUM_HI_LSB   = 32;
  localparam int FUNC_ADDR_LSB  = 35;
  localparam int FUNC_ADDR_W    = 7;
  localparam int TOKEN_LSB      = 42;
  localparam int TOKEN_W        = 2;
  localparam int KIND_LSB       = 44;
  localparam int SPLIT_POS      = 46;
  // Descriptor word 2.
  localparam int PERIOD_LSB     = 3;
  localparam int PERIOD_W       = 5;
  localparam int START_LSB      = 8;
  localparam int START_W        = 16;
  // Descriptor word 3.
  localparam int BYTES_LSB      = 32;
  localparam int BYTES_W        = 15;
  localparam int CERR_LSB       = 55;
  localparam int CERR_W         = 2;
  localparam int TOGGLE_POS     = 57;
  localparam int HALT_POS       = 62;
  localparam int ACTIVE_POS     = 63;
  // Descriptor word 4.
  localparam int MASK_LSB       = 0;
  localparam int UFRAMES        = 8;
  localparam int STATUS_LSB     = 8;
  localparam int STATUS_W       = 3;
  localparam int ST_XACT_ERR    = 0;
  localparam int ST_BABBLE      = 1;
  localparam int ST_UNDERRUN    = 2;
  // Token, endpoint kind and multiplier codes.
  localparam logic [1:0] TOKEN_OUT = 2'h0;
  localparam logic [1:0] TOKEN_IN  = 2'h1;
  localparam logic [1:0] KIND_INT  = 2'h3;
  localparam logic [1:0] MULT_UNDEF = 2'h0;
  // Processor window base and word size of the payload memory.
  localparam logic [31:0] MEM_CPU_BASE = 32'h0000_0400;
  localparam int          MEM_WORD_SHIFT = 3;

  typedef enum logic [1:0] {HSID_IDLE, HSID_ISSUE, HSID_WAIT, HSID_WRITE} hsid_state_t;

  // Converts a processor byte address to a payload memory word address.
  function automatic logic [15:0] hsid_cpu_to_word(input logic [31:0] cpu_addr);
    logic [31:0] off;
    off = (cpu_addr - MEM_CPU_BASE) >> MEM_WORD_SHIFT;
    return off[15:0];
  endfunction
endpackage
`default_nettype wire

/* rtl/hsid_exec.sv */
`default_nettype none
// What this block does
// - Status bit0 error, bit1 babble, bit2 underrun.
// - Eight status fields, microframe 0 at 10:8.
// - Issue only on matching frame with mask set.
// - Hardware sets halt flag when halted.
// - Toggle loaded by software, next value written back.
// - Two-bit error counter, software writable.
// - Write back bytes moved, fifteen bits.
// - Payload start is memory word address.
// - Period is two to the b frames, b the top set bit.
// - Bit 46 selects plain or split transaction.
// - Token 00 is OUT, 01 is IN.
// - Seven-bit function address targets the device.
// - Endpoint number from bits 34:32 and 31.
// - Clear valid when finished or fatal error.
// - Multiplier gives packets per execution.
module hsid_exec (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        desc_load,
  input  wire logic [63:0] desc_dw0,
  input  wire logic [63:0] desc_dw1,
  input  wire logic [63:0] desc_dw2,
  input  wire logic [63:0] desc_dw3,
  input  wire logic [63:0] desc_dw4,
  input  wire logic        mask_set,
  input  wire logic [7:0]  mask_set_bits,
  input  wire logic        uframe_start,
  input  wire logic [10:0] frame_number,
  input  wire logic [2:0]  uframe_index,
  input  wire logic        txn_done,
  input  wire logic        txn_error,
  input  wire logic        txn_babble,
  input  wire logic        txn_underrun,
  input  wire logic [10:0] txn_bytes,
  output logic             txn_req,
  output logic             txn_token_in,
  output logic             txn_split,
  output logic [6:0]       txn_func_addr,
  output logic [3:0]       txn_endpoint,
  output logic             txn_toggle,
  output logic [15:0]      txn_mem_word,
  output logic [10:0]      txn_len,
  output logic             desc_valid,
  output logic             wb_strobe,
  output logic [63:0]      wb_dw3,
  output logic [31:0]      wb_dw4
);
  localparam int NS = hsid_pkg::UFRAMES * hsid_pkg::STATUS_W;
  hsid_pkg::hsid_state_t st_q, st_d;
  logic [1:0]   token_q, token_d;
  logic         split_q, split_d;
  logic [6:0]   faddr_q, faddr_d;
  logic [3:0]   ep_q, ep_d;
  logic [15:0]  start_q, start_d;
  logic [4:0]   period_q, period_d;
  logic [1:0]   mult_q, mult_d;
  logic [10:0]  maxpkt_q, maxpkt_d;
  logic [14:0]  xfer_q, xfer_d;
  logic [7:0]   mask_q, mask_d;
  logic [NS-1:0] status_q, status_d;
  logic         toggle_q, toggle_d;
  logic [1:0]   cerr_q, cerr_d;
  logic [14:0]  bytes_q, bytes_d;
  logic         halt_q, halt_d;
  logic         active_q, active_d;
  logic         valid_q, valid_d;
  logic [2:0]   uf_q, uf_d;
  logic [1:0]   pkt_q, pkt_d;
  logic         req_q, req_d;
  logic [15:0]  mword_q, mword_d;
  logic [10:0]  len_q, len_d;
  logic         wb_q, wb_d;
  logic [2:0]   res_q, res_d;

  ////////////////////////////////////////////////////////////////////////////
  // Frame match and helpers.

  logic [4:0]  phase_mask;
  logic        frame_hit;
  logic [14:0] remain;
  logic [1:0]  mult_eff;

  // The highest set bit of the period field marks the period in frames and the
  // bits below it the phase; a zero field means every frame.
  always_comb begin
    phase_mask = 5'h00;
    for (int i = 0; i < hsid_pkg::PERIOD_W; i++) begin
      if (period_q[i]) begin
        phase_mask = 5'((6'h01 << i) - 6'h01);
      end
    end
    frame_hit = ((frame_number[4:0] ^ period_q) & phase_mask) == 5'h00;
    remain    = xfer_q - bytes_q;
    mult_eff  = (mult_q == hsid_pkg::MULT_UNDEF) ? 2'h1 : mult_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    logic [2:0]  res;
    logic [14:0] nbytes;
    logic        more;
    res     = 3'h0;
    nbytes  = 15'h0000;
    more    = 1'b0;
    st_d    = st_q;
    token_d = token_q;
    split_d = split_q;
    faddr_d = faddr_q;
    ep_d    = ep_q;
    start_d = start_q;
    period_d = period_q;
    mult_d  = mult_q;
    maxpkt_d = maxpkt_q;
    xfer_d  = xfer_q;
    mask_d  = mask_q;
    status_d = status_q;
    toggle_d = toggle_q;
    cerr_d  = cerr_q;
    bytes_d = bytes_q;
    halt_d  = halt_q;
    active_d = active_q;
    valid_d = valid_q;
    uf_d    = uf_q;
    pkt_d   = pkt_q;
    req_d   = 1'b0;
    mword_d = mword_q;
    len_d   = len_q;
    wb_d    = 1'b0;
    res_d   = res_q;
    unique case (st_q)
      hsid_pkg::HSID_IDLE: begin
        // A descriptor is taken only while no execution is in flight.
        if (desc_load) begin
          ep_d    = {desc_dw1[hsid_pkg::EPNUM_HI_LSB +: 3],
                     desc_dw0[hsid_pkg::EPNUM_LSB_POS]};
          faddr_d = desc_dw1[hsid_pkg::FUNC_ADDR_LSB +: hsid_pkg::FUNC_ADDR_W];
          token_d = desc_dw1[hsid_pkg::TOKEN_LSB +: hsid_pkg::TOKEN_W];
          split_d = desc_dw1[hsid_pkg::SPLIT_POS];
          start_d = desc_dw2[hsid_pkg::START_LSB +: hsid_pkg::START_W];
          period_d = desc_dw2[hsid_pkg::PERIOD_LSB +: hsid_pkg::PERIOD_W];
          mult_d  = desc_dw0[hsid_pkg::MULT_LSB +: hsid_pkg::MULT_W];
          maxpkt_d = desc_dw0[hsid_pkg::MAXPKT_LSB +: hsid_pkg::MAXPKT_W];
          xfer_d  = desc_dw0[hsid_pkg::XFER_LSB +: hsid_pkg::BYTES_W];
          valid_d = desc_dw0[hsid_pkg::VALID_POS];
          active_d = desc_dw3[hsid_pkg::ACTIVE_POS];
          halt_d  = 1'b0;
          toggle_d = desc_dw3[hsid_pkg::TOGGLE_POS];
          cerr_d  = desc_dw3[hsid_pkg::CERR_LSB +: hsid_pkg::CERR_W];
          bytes_d = 15'h0000;
          mask_d  = desc_dw4[hsid_pkg::MASK_LSB +: hsid_pkg::UFRAMES];
          status_d = desc_dw4[hsid_pkg::STATUS_LSB +: NS];
        end else if (uframe_start && valid_q && frame_hit && mask_q[uframe_index]) begin
          uf_d  = uframe_index;
          pkt_d = 2'h0;
          res_d = 3'h0;
          if (token_q != hsid_pkg::TOKEN_OUT && token_q != hsid_pkg::TOKEN_IN) begin
            // An unusable token cannot be sent, so the descriptor is retired halted.
            halt_d   = 1'b1;
            valid_d  = 1'b0;
            active_d = 1'b0;
            wb_d     = 1'b1;
          end else begin
            st_d = hsid_pkg::HSID_ISSUE;
          end
        end
      end
      hsid_pkg::HSID_ISSUE: begin
        req_d   = 1'b1;
        mword_d = start_q + 16'(bytes_q >> hsid_pkg::MEM_WORD_SHIFT);
        len_d   = (remain < 15'(maxpkt_q)) ? remain[10:0] : maxpkt_q;
        st_d    = hsid_pkg::HSID_WAIT;
      end
      hsid_pkg::HSID_WAIT: begin
        if (txn_done) begin
          res[hsid_pkg::ST_XACT_ERR] = txn_error;
          res[hsid_pkg::ST_BABBLE]   = txn_babble && (token_q == hsid_pkg::TOKEN_IN);
          res[hsid_pkg::ST_UNDERRUN] = txn_underrun && (token_q == hsid_pkg::TOKEN_OUT);
          res_d = res_q | res;
          if (res[hsid_pkg::ST_XACT_ERR]) begin
            // A zero counter means errors are not counted.
            if (cerr_q != 2'h0) begin
              cerr_d = cerr_q - 2'h1;
              halt_d = (cerr_q == 2'h1);
            end
          end else begin
            nbytes   = bytes_q + 15'(txn_bytes);
            bytes_d  = nbytes;
            toggle_d = ~toggle_q;
            more     = (pkt_q + 2'h1 < mult_eff) && (nbytes < xfer_q)
                       && (txn_bytes == len_q);
          end
          if (res[hsid_pkg::ST_BABBLE]) begin
            halt_d = 1'b1;
          end
          pkt_d = pkt_q + 2'h1;
          st_d  = (more && !res[hsid_pkg::ST_BABBLE]) ? hsid_pkg::HSID_ISSUE
                                                       : hsid_pkg::HSID_WRITE;
        end
      end
      hsid_pkg::HSID_WRITE: begin
        status_d[uf_q*hsid_pkg::STATUS_W +: hsid_pkg::STATUS_W] = res_q;
        mask_d[uf_q] = 1'b0;
        if (halt_q || bytes_q >= xfer_q || (mask_q & ~(8'h01 << uf_q)) == 8'h00) begin
          valid_d  = 1'b0;
          active_d = 1'b0;
        end
        wb_d = 1'b1;
        st_d = hsid_pkg::HSID_IDLE;
      end
    endcase
    // A software mask set in the same cycle as a hardware clear wins.
    if (mask_set) begin
      mask_d = mask_d | mask_set_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers.

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q     <= hsid_pkg::HSID_IDLE;
      token_q  <= 2'h0;
      split_q  <= 1'b0;
      faddr_q  <= 7'h00;
      ep_q     <= 4'h0;
      start_q  <= 16'h0000;
      period_q <= 5'h00;
      mult_q   <= 2'h0;
      maxpkt_q <= 11'h000;
      xfer_q   <= 15'h0000;
      mask_q   <= 8'h00;
      status_q <= '0;
      toggle_q <= 1'b0;
      cerr_q   <= 2'h0;
      bytes_q  <= 15'h0000;
      halt_q   <= 1'b0;
      active_q <= 1'b0;
      valid_q  <= 1'b0;
      uf_q     <= 3'h0;
      pkt_q    <= 2'h0;
      req_q    <= 1'b0;
      mword_q  <= 16'h0000;
      len_q    <= 11'h000;
      wb_q     <= 1'b0;
      res_q    <= 3'h0;
    end else begin
      st_q     <= st_d;
      token_q  <= token_d;
      split_q  <= split_d;
      faddr_q  <= faddr_d;
      ep_q     <= ep_d;
      start_q  <= start_d;
      period_q <= period_d;
      mult_q   <= mult_d;
      maxpkt_q <= maxpkt_d;
      xfer_q   <= xfer_d;
      mask_q   <= mask_d;
      status_q <= status_d;
      toggle_q <= toggle_d;
      cerr_q   <= cerr_d;
      bytes_q  <= bytes_d;
      halt_q   <= halt_d;
      active_q <= active_d;
      valid_q  <= valid_d;
      uf_q     <= uf_d;
      pkt_q    <= pkt_d;
      req_q    <= req_d;
      mword_q  <= mword_d;
      len_q    <= len_d;
      wb_q     <= wb_d;
      res_q    <= res_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all taken from registers.

  assign txn_req       = req_q;
  assign txn_token_in  = (token_q == hsid_pkg::TOKEN_IN);
  assign txn_split     = split_q;
  assign txn_func_addr = faddr_q;
  assign txn_endpoint  = ep_q;
  assign txn_toggle    = toggle_q;
  assign txn_mem_word  = mword_q;
  assign txn_len       = len_q;
  assign desc_valid    = valid_q;
  assign wb_strobe     = wb_q;
  assign wb_dw3 = {active_q, halt_q, 4'h0, toggle_q, cerr_q, 8'h00, bytes_q, 32'h0000_0000};
  assign wb_dw4 = {status_q, mask_q};
endmodule // hsid_exec
`default_nettype wire

/* sim/hsid_exec_asserts.sv */
`default_nettype none
module hsid_exec_asserts (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        uframe_start,
  input wire logic        txn_done,
  input wire logic        txn_req,
  input wire logic        desc_valid,
  input wire logic        wb_strobe,
  input wire logic [63:0] wb_dw3
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_quiet;
    !txn_req [*2];
  endsequence
  sequence s_next;
    ##2 (txn_req || wb_strobe);
  endsequence
  chk_req_pulse: assert property (txn_req |=> s_quiet)
    else $error("request held too long");
  chk_req_cause: assert property (txn_req |-> $past(uframe_start, 2) || $past(txn_done, 2))
    else $error("request without a cause");
  chk_done_next: assert property (txn_done |-> s_next)
    else $error("no step after done");
  chk_wb_pulse: assert property (wb_strobe |=> !wb_strobe)
    else $error("writeback held too long");
  chk_wb_cause:
    assert property (wb_strobe |-> $past(txn_done, 2) || $past(uframe_start, 1)
      || $past(uframe_start, 2)) else $error("writeback without a cause");
  chk_halt_valid: assert property (wb_strobe && wb_dw3[62] |-> !desc_valid)
    else $error("halted yet valid");
  chk_active_mirror: assert property (wb_strobe |-> wb_dw3[63] == desc_valid)
    else $error("active differs from valid");
  chk_low_zero: assert property (wb_strobe |-> {wb_dw3[61:58], wb_dw3[31:0]} == 36'h0)
    else $error("reserved writeback bits set");
endmodule // hsid_exec_asserts
bind hsid_exec hsid_exec_asserts u_hsid_exec_asserts (.clock, .rst, .uframe_start,
  .txn_done, .txn_req, .desc_valid, .wb_strobe, .wb_dw3);
`default_nettype wire

/* sim/hsid_txn_engine.sv */
`default_nettype none
module hsid_txn_engine (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        txn_req,
  input  wire logic [10:0] txn_len,
  input  wire logic        slow,
  input  wire logic [2:0]  fault,
  output logic             txn_done,
  output logic             txn_error,
  output logic             txn_babble,
  output logic             txn_underrun,
  output logic [10:0]      txn_bytes
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_q <= 4'h0;
      txn_done <= 1'b0;
      {txn_underrun, txn_babble, txn_error, txn_bytes} <= 14'h0;
    end else begin
      txn_done <= 1'b0;
      if (txn_req) begin
        wait_q <= slow ? 4'h6 : 4'h1;
      end else if (wait_q == 4'h1) begin
        txn_done <= 1'b1;
        {txn_underrun, txn_babble, txn_error} <= fault;
        txn_bytes <= txn_len;
        wait_q <= 4'h0;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end
      // Results are only good with the done pulse, so stale values are flipped.
      if (txn_done) begin
        {txn_underrun, txn_babble, txn_error, txn_bytes} <=
          ~{txn_underrun, txn_babble, txn_error, txn_bytes};
      end
    end
  end
endmodule // hsid_txn_engine
`default_nettype wire

/* sim/hs_interrupt_descriptor_exec_tb.sv */
`default_nettype none
module hs_interrupt_descriptor_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst, desc_load, mask_set, uframe_start, slow, txn_done, txn_error;
  logic        txn_babble, txn_underrun, txn_req, txn_token_in, txn_split, txn_toggle;
  logic        desc_valid, wb_strobe, m_tog, m_sp, m_valid, m_halt;
  logic [63:0] desc_dw0, desc_dw1, desc_dw2, desc_dw3, desc_dw4, wb_dw3;
  logic [31:0] wb_dw4, seed;
  logic [23:0] m_st;
  logic [15:0] txn_mem_word, m_start;
  logic [14:0] m_bytes, m_total;
  logic [10:0] frame_number, txn_bytes, txn_len, m_len;
  logic [7:0]  mask_set_bits, m_mask;
  logic [6:0]  txn_func_addr, m_fa;
  logic [3:0]  txn_endpoint, m_ep;
  logic [2:0]  uframe_index, fault;
  logic [1:0]  m_cerr, m_tok, m_mult;
  int          mismatches, samples_checked;
  hsid_exec u_hsid_exec (.clock, .rst, .desc_load, .desc_dw0, .desc_dw1, .desc_dw2, .desc_dw3,
    .desc_dw4, .mask_set, .mask_set_bits, .uframe_start, .frame_number, .uframe_index,
    .txn_done, .txn_error, .txn_babble, .txn_underrun, .txn_bytes, .txn_req, .txn_token_in,
    .txn_split, .txn_func_addr, .txn_endpoint, .txn_toggle, .txn_mem_word, .txn_len,
    .desc_valid, .wb_strobe, .wb_dw3, .wb_dw4);
  hsid_txn_engine u_hsid_txn_engine (.clock, .rst, .txn_req, .txn_len, .slow, .fault,
    .txn_done, .txn_error, .txn_babble, .txn_underrun, .txn_bytes);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: saw %h, want %h", $time, what, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic ld(input logic [1:0] tk, ce, input logic [7:0] mk, input logic [4:0] pd,
    input logic [14:0] tot);
    seed = lfsr(seed);
    {m_start, m_sp, m_tog, m_ep, m_fa} = seed[28:0];
    {m_tok, m_cerr, m_mask, m_total, m_bytes, m_st, m_halt, m_valid} =
      {tk, ce, mk, tot, 15'h0, 24'h0, 2'h1};
    @(posedge clock);
    desc_load <= 1'b1;
    desc_dw0 <= {32'h0, m_ep[0], m_mult, 11'h8, tot, 3'h1};
    desc_dw1 <= {17'h0, m_sp, 2'h3, tk, m_fa, m_ep[3:1], 32'h0};
    desc_dw2 <= {40'h0, m_start, pd, 3'h0};
    desc_dw3 <= {1'b1, 5'h0, m_tog, ce, 55'h0};
    desc_dw4 <= {56'h0, mk};
    @(posedge clock);
    desc_load <= 1'b0;
    @(negedge clock);
    chk({desc_valid, wb_dw4[7:0]}, {1'b1, mk}, "load");
  endtask
  task automatic uf(input logic [2:0] i, input logic [10:0] fr, input logic go,
    input logic [2:0] f);
    int n, want;
    n = 0;
    want = 0;
    seed = lfsr(seed);
    @(posedge clock);
    {uframe_start, uframe_index, frame_number, fault, slow} <= {1'b1, i, fr, f, seed[0]};
    @(posedge clock);
    uframe_start <= 1'b0;
    repeat (32) begin
      @(negedge clock);
      if (txn_req === 1'b1) begin
        n++;
        m_len = (m_total - m_bytes > 15'h8) ? 11'h8 : 11'(m_total - m_bytes);
        chk({txn_token_in, txn_split, txn_func_addr, txn_endpoint, txn_toggle},
          {m_tok[0], m_sp, m_fa, m_ep, m_tog}, "fields");
        chk({txn_mem_word, txn_len}, {m_start + 16'(m_bytes >> 3), m_len}, "buffer");
        // Any packet without a transaction error counts its bytes and flips the toggle.
        if (!f[0]) begin
          m_tog = ~m_tog;
          m_bytes += 15'(m_len);
        end
        want = n + int'(n < m_mult && !f[0] && !(f[1] & m_tok[0]) && m_bytes < m_total);
      end
      if (wb_strobe === 1'b1) begin
        if (m_tok[1]) begin
          {m_halt, m_valid} = 2'h2;
        end else begin
          m_st[3*i +: 3] = {f[2] & ~m_tok[0], f[1] & m_tok[0], f[0]};
          if (f[0]) begin
            m_halt = (m_cerr == 2'h1);
            if (m_cerr != 2'h0) m_cerr--;
          end
          if (f[1] & m_tok[0]) m_halt = 1'b1;
          m_mask[i] = 1'b0;
          m_valid = !(m_halt || m_bytes >= m_total || m_mask == 8'h0);
          chk(wb_dw4, {m_st, m_mask}, "status");
        end
        chk({desc_valid, wb_dw3}, {m_valid, m_valid, m_halt, 4'h0, m_tog, m_cerr, 8'h0,
          m_bytes, 32'h0}, "writeback");
      end
    end
    chk(n != 0, go, "issue");
    chk(n, want, "packets");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
  initial begin
    {rst, seed, mismatches, samples_checked} = {1'b1, 32'h0001_0620, 64'h0};
    {desc_load, mask_set, uframe_start, slow, mask_set_bits, uframe_index, fault} = '0;
    {frame_number, desc_dw0, desc_dw1, desc_dw2, desc_dw3, desc_dw4} = '0;
    m_mult = 2'h1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    // The two unused token codes must halt without reaching the bus.
    for (int t = 0; t < 4; t++) begin
      ld(2'(t), 2'h0, 8'hff, 5'h0, 15'h64);
      uf(3'h0, 11'h0, t < 2, 3'h0);
    end
    ld(hsid_pkg::TOKEN_OUT, 2'h0, 8'hff, 5'h0, 15'h14);
    for (int k = 0; k < 4; k++) uf(3'(k), 11'h0, k < 3, 3'h0);
    ld(hsid_pkg::TOKEN_IN, 2'h0, 8'h05, 5'h0, 15'h64);
    uf(3'h1, 11'h0, 1'b0, 3'h0);
    uf(3'h2, 11'h0, 1'b1, 3'h1);
    @(posedge clock);
    {mask_set, mask_set_bits} <= {1'b1, 8'h02};
    @(posedge clock);
    mask_set <= 1'b0;
    m_mask |= 8'h02;
    uf(3'h1, 11'h0, 1'b1, 3'h4);
    ld(hsid_pkg::TOKEN_IN, 2'h2, 8'hff, 5'h0, 15'h64);
    uf(3'h0, 11'h0, 1'b1, 3'h1);
    uf(3'h1, 11'h0, 1'b1, 3'h1);
    uf(3'h2, 11'h0, 1'b0, 3'h0);
    ld(hsid_pkg::TOKEN_IN, 2'h3, 8'hff, 5'h0, 15'h64);
    uf(3'h4, 11'h0, 1'b1, 3'h2);
    ld(hsid_pkg::TOKEN_OUT, 2'h1, 8'hff, 5'h0, 15'h64);
    uf(3'h7, 11'h0, 1'b1, 3'h6);
    ld(hsid_pkg::TOKEN_OUT, 2'h0, 8'hff, 5'h04, 15'h64);
    uf(3'h0, 11'h005, 1'b0, 3'h0);
    uf(3'h0, 11'h404, 1'b1, 3'h0);
    // Three packets in one microframe, the last one short, finish the transfer.
    m_mult = 2'h3;
    ld(hsid_pkg::TOKEN_OUT, 2'h0, 8'h01, 5'h0, 15'h14);
    uf(3'h0, 11'h0, 1'b1, 3'h0);
    m_mult = 2'h2;
    ld(hsid_pkg::TOKEN_IN, 2'h0, 8'hff, 5'h0, 15'h64);
    uf(3'h3, 11'h0, 1'b1, 3'h0);
    give_verdict();
  end
endmodule // hs_interrupt_descriptor_exec_tb
`default_nettype wire
